/* File: verilog/pic_cfg.svh */
// Register offsets, field positions, reset values and source layout of the interrupt controller.
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_NSRC          16
`define PIC_OFS_FLAG0     8'h00
`define PIC_OFS_FLAG7     8'h04
`define PIC_OFS_EN0       8'h08
`define PIC_OFS_EN1       8'h0C
`define PIC_OFS_EN7       8'h10
`define PIC_OFS_PRIO0     8'h14
`define PIC_OFS_CTLA      8'h18
`define PIC_OFS_CTLB      8'h1C
`define PIC_OFS_STATUS    8'h20
`define PIC_OFS_CORE      8'h24
`define PIC_OFS_VLATCH    8'h28
`define PIC_FLAG0_MASK    16'h000F
`define PIC_FLAG7_MASK    16'h0013
`define PIC_EN0_MASK      16'h000F
`define PIC_EN1_MASK      16'h201F
`define PIC_EN7_MASK      16'h0013
`define PIC_PRIO0_MASK    16'h7777
`define PIC_PRIO0_RST     16'h4444
`define PIC_CTLA_MASK     16'h801F
`define PIC_CTLB_MASK     16'hE007
`define PIC_NESTING_DISABLE_BIT    15
`define PIC_IPL_LSB       5
`define PIC_PRIORITY_LEVEL_MSB_BIT      3
`define PIC_VEC_BASE      7'h08
`endif

/* File: verilog/pic_pkg.sv */
// Types shared by the interrupt controller files.
`default_nettype none
package pic_pkg;
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_POST = 3'b010,
    PIC_WAIT = 3'b100
  } pic_state_t;
endpackage
`default_nettype wire

/* File: verilog/pic_src.sv */
// One interrupt source: flag, qualification and effective priority.
`timescale 1ns/1ps
`default_nettype none
module pic_src (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       evt,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [2:0] prio,
  input  wire logic [3:0] cur_ipl,
  output logic            flag_ff,
  output logic            qual,
  output logic [2:0]      eff_prio
);
  logic nxt_flag;
  // Hardware set wins over a software clear in the same cycle.
  assign nxt_flag = evt | (flag_ff & ~clr);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  // Disabled, priority zero, or not above the CPU level never qualifies.
  assign qual     = flag_ff & en & (prio != 3'h0) & ({1'b0, prio} > cur_ipl);
  assign eff_prio = qual ? prio : 3'h0;
endmodule
`default_nettype wire

/* File: verilog/pic_top.sv */
// Prioritising interrupt controller with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module pic_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] src_evt,
  input  wire logic [4:0]  trap_evt,
  input  wire logic        trap_level_set,
  input  wire logic        trap_level_clr,
  input  wire logic        irq_ack,
  output logic             irq_req,
  output logic [6:0]       irq_vector,
  output logic [3:0]       irq_level,
  output logic             alt_vector_sel,
  output logic [2:0]       ext_edge_sel
);
  // ==========================================================================
  // Bus slave.
  logic        wr_pend_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] hrdata_ff;
  logic        acc;
  logic        rd_acc;
  logic [7:0]  aoff;
  logic [15:0] rd_val;
  assign acc    = hsel & hready & htrans[1];
  assign rd_acc = acc & ~hwrite;
  assign aoff   = haddr[7:0];

  // ==========================================================================
  // Registers.
  logic [15:0] flag0_clr_ff;
  logic [15:0] en0_ff;
  logic [15:0] en1_ff;
  logic [15:0] en7_ff;
  logic [15:0] prio0_ff;
  logic [15:0] ctla_ff;
  logic [15:0] ctlb_ff;
  logic [2:0]  ipl_ff;
  logic        priority_level_msb_ff;
  logic [6:0]  vec_ff;
  logic [3:0]  lvl_ff;
  logic        irq_req_ff;
  pic_pkg::pic_state_t state_ff;
  pic_pkg::pic_state_t nxt_state;

  logic        wr_flag0;
  logic        wr_flag7;
  logic        wr_en0;
  logic        wr_en1;
  logic        wr_en7;
  logic        wr_prio0;
  logic        wr_ctla;
  logic        wr_ctlb;
  logic        wr_stat;
  logic [15:0] wd;
  assign wd       = hwdata[15:0];
  assign wr_flag0 = wr_pend_ff & (waddr_ff == `PIC_OFS_FLAG0);
  assign wr_flag7 = wr_pend_ff & (waddr_ff == `PIC_OFS_FLAG7);
  assign wr_en0   = wr_pend_ff & (waddr_ff == `PIC_OFS_EN0);
  assign wr_en1   = wr_pend_ff & (waddr_ff == `PIC_OFS_EN1);
  assign wr_en7   = wr_pend_ff & (waddr_ff == `PIC_OFS_EN7);
  assign wr_prio0 = wr_pend_ff & (waddr_ff == `PIC_OFS_PRIO0);
  assign wr_ctla  = wr_pend_ff & (waddr_ff == `PIC_OFS_CTLA);
  assign wr_ctlb  = wr_pend_ff & (waddr_ff == `PIC_OFS_CTLB);
  assign wr_stat  = wr_pend_ff & (waddr_ff == `PIC_OFS_STATUS);

  // ==========================================================================
  // Source table, vector-table order.
  logic [15:0] flags;
  logic [15:0] clrs;
  logic [15:0] ens;
  logic [47:0] prios;
  logic [15:0] quals;
  logic [47:0] effs;
  logic [3:0]  cur_ipl;
  assign cur_ipl = {priority_level_msb_ff, ipl_ff};
  // Sources 0..3 live in flag/enable/priority group 0; 4..6 are the ADC pair sources.
  assign clrs = {9'h000, {3{wr_flag7}} & ~{wd[4], wd[1], wd[0]},
                 {4{wr_flag0}} & ~wd[3:0]};
  assign ens   = {9'h000, en7_ff[4], en7_ff[1], en7_ff[0], en0_ff[3:0]};
  assign prios = {27'h0, 3'h4, 3'h4, 3'h4, prio0_ff[14:12], prio0_ff[10:8],
                  prio0_ff[6:4], prio0_ff[2:0]};

  genvar gi;
  generate
    for (gi = 0; gi < `PIC_NSRC; gi = gi + 1) begin : g_src
      pic_src u_src (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .evt      (src_evt[gi]),
        .clr      (clrs[gi]),
        .en       (ens[gi]),
        .prio     (prios[3*gi +: 3]),
        .cur_ipl  (cur_ipl),
        .flag_ff  (flags[gi]),
        .qual     (quals[gi]),
        .eff_prio (effs[3*gi +: 3])
      );
    end
  endgenerate

  // ==========================================================================
  // Arbitration: strictly greater wins, so the lower index keeps ties.
  logic [2:0] best_p;
  logic [3:0] best_i;
  always_comb begin
    best_p = 3'h0;
    best_i = 4'h0;
    for (int i = 0; i < `PIC_NSRC; i++) begin
      if (effs[3*i +: 3] > best_p) begin
        best_p = effs[3*i +: 3];
        best_i = 4'(i);
      end
    end
  end
  logic any_q;
  // Qualification already excludes everything at or below the CPU level, so
  // level 7 and any level with the MSB set leave nothing pending.
  assign any_q = |quals;

  // ==========================================================================
  // Request state machine.
  always_comb begin
    case (state_ff)
      pic_pkg::PIC_IDLE: nxt_state = any_q ? pic_pkg::PIC_POST : pic_pkg::PIC_IDLE;
      // The request is withdrawn once nothing qualifies any longer.
      pic_pkg::PIC_POST: nxt_state = irq_ack ? pic_pkg::PIC_WAIT :
                                     (any_q ? pic_pkg::PIC_POST : pic_pkg::PIC_IDLE);
      pic_pkg::PIC_WAIT: nxt_state = pic_pkg::PIC_IDLE;
      default:           nxt_state = pic_pkg::PIC_IDLE;
    endcase
  end
  logic take;
  assign take = (state_ff == pic_pkg::PIC_IDLE) & any_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= pic_pkg::PIC_IDLE;
      vec_ff     <= 7'h00;
      lvl_ff     <= 4'h0;
      irq_req_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      irq_req_ff <= (nxt_state == pic_pkg::PIC_POST);
      if (take) begin
        vec_ff <= `PIC_VEC_BASE + {3'h0, best_i};
        lvl_ff <= {1'b0, best_p};
      end
    end
  end

  // ==========================================================================
  // Register writes.
  logic [2:0] nxt_ipl;
  assign nxt_ipl = (wr_stat & ~ctla_ff[`PIC_NESTING_DISABLE_BIT]) ? wd[`PIC_IPL_LSB +: 3] : ipl_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en0_ff   <= 16'h0000;
      en1_ff   <= 16'h0000;
      en7_ff   <= 16'h0000;
      prio0_ff <= `PIC_PRIO0_RST;
      ctla_ff  <= 16'h0000;
      ctlb_ff  <= 16'h0000;
      ipl_ff   <= 3'h0;
      priority_level_msb_ff  <= 1'b0;
    end else begin
      if (wr_en0) en0_ff <= wd & `PIC_EN0_MASK;
      if (wr_en1) en1_ff <= wd & `PIC_EN1_MASK;
      if (wr_en7) en7_ff <= wd & `PIC_EN7_MASK;
      if (wr_prio0) prio0_ff <= wd & `PIC_PRIO0_MASK;
      // Trap status bits 4:0 are set by hardware; set wins over a write.
      ctla_ff <= ((wr_ctla ? wd : ctla_ff) | {11'h000, trap_evt}) & `PIC_CTLA_MASK;
      if (wr_ctlb) ctlb_ff <= wd & `PIC_CTLB_MASK;
      ipl_ff <= nxt_ipl;
      // Only the core's trap logic moves the MSB; software cannot.
      if (trap_level_set) priority_level_msb_ff <= 1'b1;
      else if (trap_level_clr) priority_level_msb_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux.
  assign rd_val =
    (aoff == `PIC_OFS_FLAG0)  ? {12'h000, flags[3:0]} :
    (aoff == `PIC_OFS_FLAG7)  ? {11'h000, flags[6], 2'b00, flags[5:4]} :
    (aoff == `PIC_OFS_EN0)    ? en0_ff :
    (aoff == `PIC_OFS_EN1)    ? en1_ff :
    (aoff == `PIC_OFS_EN7)    ? en7_ff :
    (aoff == `PIC_OFS_PRIO0)  ? prio0_ff :
    (aoff == `PIC_OFS_CTLA)   ? ctla_ff :
    (aoff == `PIC_OFS_CTLB)   ? ctlb_ff :
    (aoff == `PIC_OFS_STATUS) ? {8'h00, ipl_ff, 5'h00} :
    (aoff == `PIC_OFS_CORE)   ? {12'h000, priority_level_msb_ff, 3'h0} :
    (aoff == `PIC_OFS_VLATCH) ? {4'h0, lvl_ff, 1'b0, vec_ff} :
    16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= acc & hwrite;
      if (acc) waddr_ff <= aoff;
      if (rd_acc) hrdata_ff <= {16'h0000, rd_val};
    end
  end

  assign hrdata         = hrdata_ff;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign irq_req        = irq_req_ff;
  assign irq_vector     = vec_ff;
  assign irq_level      = lvl_ff;
  assign alt_vector_sel = ctlb_ff[15];
  assign ext_edge_sel   = ctlb_ff[2:0];

  // ==========================================================================
  // Assertions.
  property p_req_needs_latch;
    @(posedge hclk) disable iff (!hresetn)
      irq_req |-> (irq_level != 4'h0) && (irq_vector >= `PIC_VEC_BASE);
  endproperty
  a_req_needs_latch: assert property (p_req_needs_latch) else $error("request without latch");

  property p_latch_stable;
    @(posedge hclk) disable iff (!hresetn)
      (irq_req && !irq_ack) |=> $stable(irq_vector) && $stable(irq_level);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("latch moved while pending");

  property p_level_above_cpu;
    @(posedge hclk) disable iff (!hresetn)
      take |=> ({1'b0, irq_level[2:0]} > $past(cur_ipl));
  endproperty
  a_level_above_cpu: assert property (p_level_above_cpu) else $error("level not above CPU");

  property p_msb_blocks;
    @(posedge hclk) disable iff (!hresetn)
      priority_level_msb_ff |-> !any_q;
  endproperty
  a_msb_blocks: assert property (p_msb_blocks) else $error("MSB did not block");

  property p_lvl7_blocks;
    @(posedge hclk) disable iff (!hresetn)
      (ipl_ff == 3'h7) |-> !any_q;
  endproperty
  a_lvl7_blocks: assert property (p_lvl7_blocks) else $error("level 7 did not block");

  property p_nesting_disable_lock;
    @(posedge hclk) disable iff (!hresetn)
      ctla_ff[`PIC_NESTING_DISABLE_BIT] && wr_stat |=> $stable(ipl_ff);
  endproperty
  a_nesting_disable_lock: assert property (p_nesting_disable_lock) else $error("level written while locked");

  property p_disabled_quiet;
    @(posedge hclk) disable iff (!hresetn)
      (ens == 16'h0000) |-> !any_q;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source qualified");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
      src_evt[0] |=> flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag missed event");

  property p_unimpl_zero;
    @(posedge hclk) disable iff (!hresetn)
      (en1_ff & ~`PIC_EN1_MASK) == 16'h0000 && (prio0_ff & ~`PIC_PRIO0_MASK) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");
endmodule
`default_nettype wire

/* File: test/pic_core_model.sv */
// Processor core model that takes interrupt requests after a set delay.
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       irq_req,
  input  wire logic [2:0] ack_dly,
  output logic            irq_ack
);
  // ==========================================================
  // Acknowledge
  logic [2:0] cnt_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 3'h0;
      irq_ack <= 1'h0;
    end else begin
      irq_ack <= irq_req && !irq_ack && (cnt_ff == ack_dly);
      cnt_ff  <= (irq_req && !irq_ack && (cnt_ff != ack_dly)) ? cnt_ff + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

/* File: test/priority_interrupt_controller_tb_top.sv */
// Self-checking testbench of the prioritising interrupt controller.
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module priority_interrupt_controller_tb_top;
  // ==========================================================
  // Signals
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] src_evt = 16'h0;
  logic [4:0]  trap_evt = 5'h0;
  logic        trap_level_set = 1'h0;
  logic        trap_level_clr = 1'h0;
  logic        irq_ack;
  logic        irq_req;
  logic [6:0]  irq_vector;
  logic [3:0]  irq_level;
  logic        alt_vector_sel;
  logic [2:0]  ext_edge_sel;
  logic [2:0]  ack_dly = 3'h0;
  logic [31:0] rd;
  logic [15:0] ev;
  int          errors = 0;
  int          n_checks = 0;
  int          en[7];
  int          pr[7];
  int          fl[7];
  int          w;
  int          lvl;
  logic [7:0]  ra[11] = '{`PIC_OFS_FLAG0, `PIC_OFS_FLAG7, `PIC_OFS_EN0, `PIC_OFS_EN1,
    `PIC_OFS_EN7, `PIC_OFS_PRIO0, `PIC_OFS_CTLB, `PIC_OFS_STATUS, `PIC_OFS_CORE,
    `PIC_OFS_CTLA, 8'h30};
  logic [15:0] rw[11] = '{16'h0, 16'h0, `PIC_EN0_MASK, `PIC_EN1_MASK, `PIC_EN7_MASK,
    `PIC_PRIO0_MASK, `PIC_CTLB_MASK, 16'h00E0, 16'h0, 16'h801F, 16'h0};

  always #5 hclk = ~hclk;

  pic_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_evt(src_evt),
    .trap_evt(trap_evt), .trap_level_set(trap_level_set), .trap_level_clr(trap_level_clr),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .alt_vector_sel(alt_vector_sel), .ext_edge_sel(ext_edge_sel));

  pic_core_model core_u (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
    .ack_dly(ack_dly), .irq_ack(irq_ack));

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (hreadyout !== 1'h1) errors++;
  endtask

  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr_en;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic pulse_src(input logic [15:0] v);
    src_evt <= v;
    @(posedge hclk);
    src_evt <= 16'h0;
    for (int i = 0; i < 7; i++) fl[i] = v[i];
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 12 && irq_req !== 1'h1; k++) @(negedge hclk);
  endtask

  task automatic setup_irq(input int l);
    logic [15:0] v;
    v = 16'h0;
    for (int i = 0; i < 4; i++) v[i] = en[i][0];
    wr(`PIC_OFS_EN0, {16'h0, v});
    wr(`PIC_OFS_EN7, {27'h0, en[6][0], 2'h0, en[5][0], en[4][0]});
    v = {1'h0, pr[3][2:0], 1'h0, pr[2][2:0], 1'h0, pr[1][2:0], 1'h0, pr[0][2:0]};
    wr(`PIC_OFS_PRIO0, {16'h0, v});
    wr(`PIC_OFS_STATUS, 32'(l) << 5);
    rdc("cpu_status_reg", `PIC_OFS_STATUS, 32'(l) << 5);
  endtask

  task automatic clear();
    wr(`PIC_OFS_FLAG0, 32'h0);
    wr(`PIC_OFS_FLAG7, 32'h0);
    repeat (12) @(posedge hclk);
    chk("irq_req idle", 32'h0, irq_req);
  endtask

  function automatic int eprio(int i);
    return (i < 4) ? pr[i] : 4;
  endfunction

  function automatic int winner(int l);
    int b;
    b = -1;
    for (int i = 0; i < 7; i++) begin
      if (fl[i] != 0 && en[i] != 0 && eprio(i) > l && (b < 0 || eprio(i) > eprio(b))) begin
        b = i;
      end
    end
    return b;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h86826920));
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int i = 0; i < 11; i++) begin
      rdc("reset value", ra[i], (i == 5) ? `PIC_PRIO0_RST : 32'h0);
      wr(ra[i], 32'hFFFFFFFF);
      rdc("write mask", ra[i], {16'h0, rw[i]});
      if (i == 6) begin
        chk("alt_vector_sel", 32'h1, alt_vector_sel);
        chk("ext_edge_sel", 32'h7, ext_edge_sel);
      end
      wr(ra[i], 32'h0);
    end
    chk("hresp", 32'h0, hresp);
    trap_evt <= 5'h15;
    @(posedge hclk);
    trap_evt <= 5'h0;
    rdc("trap status", `PIC_OFS_CTLA, 32'h15);
    wr(`PIC_OFS_CTLA, 32'h8000);
    wr(`PIC_OFS_STATUS, 32'hE0);
    rdc("locked level", `PIC_OFS_STATUS, 32'h0);
    wr(`PIC_OFS_CTLA, 32'h0);
    for (int i = 0; i < 7; i++) en[i] = (i == 0);
    pr[0] = 7;
    setup_irq(7);
    pulse_src(16'h1);
    wait_irq();
    chk("irq_req level 7", 32'h0, irq_req);
    @(posedge hclk);
    trap_level_set <= 1'h1;
    @(posedge hclk);
    trap_level_set <= 1'h0;
    wr(`PIC_OFS_STATUS, 32'h0);
    wr(`PIC_OFS_CORE, 32'h0);
    rdc("level msb", `PIC_OFS_CORE, 32'h8);
    wait_irq();
    chk("irq_req msb", 32'h0, irq_req);
    @(posedge hclk);
    trap_level_clr <= 1'h1;
    @(posedge hclk);
    trap_level_clr <= 1'h0;
    wait_irq();
    chk("irq_vector", 32'h8, irq_vector);
    @(posedge hclk);
    clear();
    for (int t = 0; t < 40; t++) begin
      lvl = $urandom % 8;
      for (int i = 0; i < 7; i++) begin
        en[i] = $urandom % 2;
        pr[i] = $urandom % 8;
      end
      ack_dly <= 3'($urandom % 5);
      setup_irq(lvl);
      ev = 16'($urandom);
      pulse_src(ev);
      w = winner(lvl);
      wait_irq();
      chk("irq_req", 32'(w >= 0), irq_req);
      if (w >= 0) begin
        chk("irq_vector", 32'(8 + w), irq_vector);
        chk("irq_level", 32'(eprio(w)), irq_level);
      end
      @(posedge hclk);
      rdc("flag group 0", `PIC_OFS_FLAG0, {28'h0, ev[3:0]});
      rdc("flag group 7", `PIC_OFS_FLAG7, {27'h0, ev[6], 2'h0, ev[5:4]});
      if (w >= 0) begin
        rdc("vector latch", `PIC_OFS_VLATCH, 32'((eprio(w) << 8) | (8 + w)));
      end
      clear();
    end
    complete_run();
  end
endmodule
`default_nettype wire
